//--- byte_reg.v
/*
  One byte-wide read/write register with a power-on value.
  Assumes write strobe synchronous to sys_clk_i.
*/
`timescale 1ns/1ns
module byte_reg #(
  parameter [7:0] RESET_VALUE = 8'h00
) (
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire clk_en_i,
  input wire wr_i,
  input wire [7:0] wdata_i,
  output reg [7:0] q_o
);
  // ----------------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------------
  // Constant on reset; frozen while the clock enable is low
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q_o <= RESET_VALUE;
    end else if (clk_en_i && wr_i) begin
      q_o <= wdata_i;
    end
  end
endmodule // byte_reg

//--- host_port_model.sv
/*
  Host side of the serial host port front end: single byte writes and reads.
  Assumes the bench owns clk_en_i; strobes move on falling edges.
*/
`timescale 1ns/1ns
module host_port_model (
  input wire sys_clk_i,
  input wire [7:0] rdata_i,
  input wire rvalid_i,
  input wire hit_i,
  output reg [7:0] addr_o,
  output reg wr_o,
  output reg rd_o,
  output reg [7:0] wdata_o
);
  // ------------------------------------------------------------
  // Transfers
  // ------------------------------------------------------------
  // Idle host: no strobes at time zero
  initial begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end
  // One-cycle write; data inverted after so stale values never pass
  task wr_byte(input [7:0] a, input [7:0] d);
    begin
      @(negedge sys_clk_i);
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(negedge sys_clk_i);
      wr_o = 1'b0;
      wdata_o = ~d;
    end
  endtask
  // One-cycle read; answer is registered, so it is there one edge later
  task rd_byte(input [7:0] a, output [7:0] d, output h, output v);
    begin
      @(negedge sys_clk_i);
      addr_o = a;
      rd_o = 1'b1;
      @(negedge sys_clk_i);
      rd_o = 1'b0;
      d = rdata_i;
      h = hit_i;
      v = rvalid_i;
    end
  endtask
endmodule // host_port_model

//--- pll1_bank_checker.sv
/*
  Port assertions for the first PLL configuration bank.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ns
module pll1_bank_checker (
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire clk_en_i,
  input wire [7:0] addr_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] wdata_i,
  input wire [7:0] rdata_o,
  input wire rvalid_o,
  input wire hit_o,
  input wire bias_current_select_o,
  input wire [5:0] ref_prediv_o,
  input wire [10:0] fb_divider_o,
  input wire [5:0] pump_weights_o,
  input wire pump_divide_24_o,
  input wire pump_divide_3_o,
  input wire [7:0] pump_numerator_o,
  input wire [4:0] pump_divisor_o,
  input wire [15:0] spread_feedback_divider_o
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Accepted write strobe; clk_en low must freeze everything
  wire wr_go = clk_en_i && wr_i;
  read_pulse_a: assert property (clk_en_i && rd_i |=> rvalid_o)
    else $error("read answer missing");
  // With the clock enable low the answer is frozen; a running idle cycle drops rvalid_o and keeps rdata_o
  read_hold_a: assert property (clk_en_i && !rd_i |=> !rvalid_o && $stable(rdata_o))
    else $error("read outputs moved without a read");
  miss_read_a: assert property (clk_en_i && rd_i && (addr_i < 8'h07 || addr_i > 8'h0f)
    |=> rdata_o == 8'h00 && !hit_o) else $error("unmapped read answered");
  prediv_wr_a: assert property (wr_go && addr_i == 8'h08 |=> ref_prediv_o == $past(wdata_i[5:0]))
    else $error("pre-divider write lost");
  fb_split_a: assert property (wr_go && addr_i == 8'h0a |=> fb_divider_o[10:8] == $past(wdata_i[2:0]))
    else $error("feedback high bits write lost");
  pump_wr_a: assert property (wr_go && addr_i == 8'h0b
    |=> {pump_weights_o, pump_divide_24_o, pump_divide_3_o} == $past(wdata_i)) else $error("pump byte lost");
  pump_calc_a: assert property (pump_numerator_o == ({2'b00, pump_weights_o} << bias_current_select_o)
    && pump_divisor_o == (pump_divide_24_o ? 5'd24 : 5'd0) + (pump_divide_3_o ? 5'd3 : 5'd0))
    else $error("pump ratio wrong");
  spread_high_a: assert property (wr_go && addr_i == 8'h0d
    |=> spread_feedback_divider_o[15:8] == $past(wdata_i)) else $error("spread high byte lost");
  frozen_a: assert property (!clk_en_i |=> $stable(fb_divider_o) && $stable(ref_prediv_o))
    else $error("state moved with clock enable low");
endmodule // pll1_bank_checker
bind pll1_config_register_bank pll1_bank_checker chk_u (.*);

//--- pll1_bank_map.vh
/*
  Register offsets, field positions and power-on values of the first PLL's configuration bank.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef PLL1_BANK_MAP_VH
`define PLL1_BANK_MAP_VH
// ----------------------------------------------------------------------------
// Byte offsets
// ----------------------------------------------------------------------------
`define OFS_PLL1_CTRL_AND_DIV5 8'h07
`define OFS_PLL1_REF_PREDIV 8'h08
`define OFS_PLL1_FB_DIV_LOW 8'h09
`define OFS_PLL1_LOOP_FILTER_FB_HIGH 8'h0a
`define OFS_PLL1_PUMP_CURRENT 8'h0b
`define OFS_PLL1_SPREAD_REF_DIV 8'h0c
`define OFS_PLL1_SPREAD_FB_HIGH 8'h0d
`define OFS_PLL1_SPREAD_FB_LOW 8'h0e
`define OFS_OUT_DIV_ONE_TWO 8'h0f
// ----------------------------------------------------------------------------
// Power-on values
// ----------------------------------------------------------------------------
`define RST_PLL1_CTRL_AND_DIV5 8'h23
`define RST_PLL1_REF_PREDIV 8'h19
`define RST_PLL1_FB_DIV_LOW 8'h58
`define RST_PLL1_LOOP_FILTER_FB_HIGH 8'hb2
`define RST_PLL1_PUMP_CURRENT 8'h06
`define RST_PLL1_SPREAD_REF_DIV 8'h00
`define RST_PLL1_SPREAD_FB_HIGH 8'h00
`define RST_PLL1_SPREAD_FB_LOW 8'h00
`define RST_OUT_DIV_ONE_TWO 8'h33
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BIT_REF_DOUBLER 7
`define BIT_BIAS_SELECT 6
`define BIT_SECOND_CHANNEL 5
`define BIT_THIRD_POLE 4
`define DIV5_HI 3
`define DIV5_LO 0
`define BIT_BYPASS_ONE 7
`define BIT_BYPASS_TWO 6
`define PREDIV_HI 5
`define PREDIV_LO 0
`define BIT_RES_100K 7
`define BIT_RES_50K 6
`define BIT_RES_25K 5
`define BIT_RES_12K5 4
`define BIT_RES_1K 3
`define FBHI_HI 2
`define FBHI_LO 0
`define PUMP_W_HI 7
`define PUMP_W_LO 2
`define BIT_PUMP_DIV24 1
`define BIT_PUMP_DIV3 0
`define BIT_SPREAD_23 7
`define SREF_HI 6
`define SREF_LO 0
`define OD1_HI 7
`define OD1_LO 4
`define OD2_HI 3
`define OD2_LO 0
`endif

//--- pll1_config_register_bank.v
/*
  Configuration byte bank of the first PLL and three output dividers, offsets 07h..0Fh.
  Assumes a serial host port front end on sys_clk_i that presents a byte address,
  one-cycle write/read strobes and write data; reads answer the next cycle.
*/
`timescale 1ns/1ns
`include "pll1_bank_map.vh"
module pll1_config_register_bank #(
  parameter NUM_BYTES = 9
) (
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire clk_en_i,
  input wire [7:0] addr_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] wdata_i,
  output reg [7:0] rdata_o,
  output reg rvalid_o,
  output reg hit_o,
  output wire ref_doubler_enable_o,
  output wire bias_current_select_o,
  output wire second_channel_enable_o,
  output wire third_pole_enable_o,
  output wire [3:0] fifth_output_divider_o,
  output wire prediv_bypass_by_one_o,
  output wire prediv_bypass_by_two_o,
  output wire [5:0] ref_prediv_o,
  output wire [10:0] fb_divider_o,
  output wire filter_res_100k_o,
  output wire filter_res_50k_o,
  output wire filter_res_25k_o,
  output wire filter_res_12k5_o,
  output wire filter_res_1k_only_o,
  output wire [5:0] pump_weights_o,
  output wire pump_divide_24_o,
  output wire pump_divide_3_o,
  output wire [7:0] pump_numerator_o,
  output wire [4:0] pump_divisor_o,
  output wire spread_ref_div_23_o,
  output wire [6:0] spread_ref_divider_o,
  output wire [15:0] spread_feedback_divider_o,
  output wire [3:0] first_output_divider_o,
  output wire [3:0] second_output_divider_o
);
  // ----------------------------------------------------------------------------
  // Byte storage
  // ----------------------------------------------------------------------------
  wire [7:0] byte_q [0:8];
  // Power-on values must be elaboration constants to serve as register parameters
  localparam [8*9-1:0] reset_values = {
    `RST_OUT_DIV_ONE_TWO, `RST_PLL1_SPREAD_FB_LOW, `RST_PLL1_SPREAD_FB_HIGH,
    `RST_PLL1_SPREAD_REF_DIV, `RST_PLL1_PUMP_CURRENT, `RST_PLL1_LOOP_FILTER_FB_HIGH,
    `RST_PLL1_FB_DIV_LOW, `RST_PLL1_REF_PREDIV, `RST_PLL1_CTRL_AND_DIV5};
  wire in_range = (addr_i >= `OFS_PLL1_CTRL_AND_DIV5) && (addr_i <= `OFS_OUT_DIV_ONE_TWO);
  wire [7:0] index = addr_i - `OFS_PLL1_CTRL_AND_DIV5;

  // One register per byte; a write to one byte never touches its neighbours
  genvar g;
  generate
    for (g = 0; g < 9; g = g + 1) begin : g_byte
      byte_reg #(
        .RESET_VALUE(reset_values[8*g+7:8*g])
      ) u_byte (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i),
        .wr_i(wr_i && in_range && (index == g)),
        .wdata_i(wdata_i),
        .q_o(byte_q[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------------
  // Registered answer; unmapped offsets read zero with hit low
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
      hit_o <= 1'b0;
    end else if (clk_en_i) begin
      rvalid_o <= rd_i;
      if (rd_i) begin
        hit_o <= in_range;
        rdata_o <= in_range ? byte_q[index[3:0]] : 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------------------
  wire [7:0] ctrl = byte_q[0];
  wire [7:0] pre = byte_q[1];
  wire [7:0] lf = byte_q[3];
  wire [7:0] cp = byte_q[4];
  wire [7:0] sref = byte_q[5];
  assign ref_doubler_enable_o = ctrl[`BIT_REF_DOUBLER];
  assign bias_current_select_o = ctrl[`BIT_BIAS_SELECT];
  assign second_channel_enable_o = ctrl[`BIT_SECOND_CHANNEL];
  assign third_pole_enable_o = ctrl[`BIT_THIRD_POLE];
  assign fifth_output_divider_o = ctrl[`DIV5_HI:`DIV5_LO];
  assign prediv_bypass_by_one_o = pre[`BIT_BYPASS_ONE];
  assign prediv_bypass_by_two_o = pre[`BIT_BYPASS_TWO];
  // Ratios outside 3..64 are stored as written; range is software's duty
  assign ref_prediv_o = pre[`PREDIV_HI:`PREDIV_LO];
  // Split field updates one byte at a time, so software writes both halves
  assign fb_divider_o = {lf[`FBHI_HI:`FBHI_LO], byte_q[2]};
  assign filter_res_100k_o = lf[`BIT_RES_100K];
  assign filter_res_50k_o = lf[`BIT_RES_50K];
  assign filter_res_25k_o = lf[`BIT_RES_25K];
  assign filter_res_12k5_o = lf[`BIT_RES_12K5];
  assign filter_res_1k_only_o = lf[`BIT_RES_1K];
  assign pump_weights_o = cp[`PUMP_W_HI:`PUMP_W_LO];
  assign pump_divide_24_o = cp[`BIT_PUMP_DIV24];
  assign pump_divide_3_o = cp[`BIT_PUMP_DIV3];
  assign spread_ref_div_23_o = sref[`BIT_SPREAD_23];
  assign spread_ref_divider_o = sref[`SREF_HI:`SREF_LO];
  assign spread_feedback_divider_o = {byte_q[6], byte_q[7]};
  assign first_output_divider_o = byte_q[8][`OD1_HI:`OD1_LO];
  assign second_output_divider_o = byte_q[8][`OD2_HI:`OD2_LO];

  // ----------------------------------------------------------------------------
  // Charge-pump ratio
  // ----------------------------------------------------------------------------
  pump_current_calc u_pump (
    .bias_select_bit_i(bias_current_select_o),
    .weights_i(pump_weights_o),
    .pump_divide_24_i(pump_divide_24_o),
    .pump_divide_3_i(pump_divide_3_o),
    .numerator_o(pump_numerator_o),
    .divisor_o(pump_divisor_o)
  );
endmodule // pll1_config_register_bank

//--- pll1_config_register_bank_tb.sv
/*
  Self-checking bench for the first PLL configuration bank.
  Assumes the host port model and the bound checker.
*/
`timescale 1ns/1ns
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module pll1_config_register_bank_tb;
  localparam [71:0] POR = {8'h23, 8'h19, 8'h58, 8'hb2, 8'h06,
    8'h00, 8'h00, 8'h00, 8'h33};
  reg sys_clk_i, reset_n_i, clk_en_i, h, v;
  reg [7:0] d;
  wire [7:0] addr, wdata, rdata, pump_num;
  wire wr, rd, rvalid, hit;
  wire [7:0] ctrl_f, cp_f, sref_f, od_f;
  wire [4:0] res_f;
  wire [1:0] byp_f;
  wire [10:0] fb_div;
  wire [5:0] prediv;
  wire [4:0] pump_div;
  wire [15:0] spread_fb;
  integer n_mismatch = 0, samples_checked = 0, cycles = 0, i;
  pll1_config_register_bank dut_u (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i), .addr_i(addr), .wr_i(wr), .rd_i(rd), .wdata_i(wdata), .rdata_o(rdata),
    .rvalid_o(rvalid), .hit_o(hit), .ref_doubler_enable_o(ctrl_f[7]),
    .bias_current_select_o(ctrl_f[6]), .second_channel_enable_o(ctrl_f[5]),
    .third_pole_enable_o(ctrl_f[4]), .fifth_output_divider_o(ctrl_f[3:0]),
    .prediv_bypass_by_one_o(byp_f[1]), .prediv_bypass_by_two_o(byp_f[0]), .ref_prediv_o(prediv),
    .fb_divider_o(fb_div), .filter_res_100k_o(res_f[4]), .filter_res_50k_o(res_f[3]),
    .filter_res_25k_o(res_f[2]), .filter_res_12k5_o(res_f[1]), .filter_res_1k_only_o(res_f[0]),
    .pump_weights_o(cp_f[7:2]), .pump_divide_24_o(cp_f[1]), .pump_divide_3_o(cp_f[0]),
    .pump_numerator_o(pump_num), .pump_divisor_o(pump_div), .spread_ref_div_23_o(sref_f[7]),
    .spread_ref_divider_o(sref_f[6:0]), .spread_feedback_divider_o(spread_fb),
    .first_output_divider_o(od_f[7:4]), .second_output_divider_o(od_f[3:0]));
  host_port_model host_u (.sys_clk_i(sys_clk_i), .rdata_i(rdata), .rvalid_i(rvalid),
    .hit_i(hit), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
  // ------------------------------------------------------------
  // Clock, watchdog, helpers
  // ------------------------------------------------------------
  // 100 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // Watchdog sized well above the hundred or so cycles the tests need
  always @(posedge sys_clk_i) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      stop_test;
    end
  end
  task stop_test;
    begin
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task check_rd(input [7:0] a, input [7:0] e, input eh);
    begin
      host_u.rd_byte(a, d, h, v);
      `CHK("rdata", e, d)
      `CHK("hit", eh, h)
      `CHK("rvalid", 1'b1, v)
    end
  endtask
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  // Defaults, readback, pump ratio, unmapped, freeze, second reset
  initial begin
    clk_en_i = 1'b1;
    reset_n_i = 1'b0;
    repeat (20) @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    for (i = 0; i < 9; i++) check_rd(8'h07 + i[7:0], POR[71 - 8 * i -: 8], 1'b1);
    `CHK("fb_div", 11'd600, fb_div)
    `CHK("prediv", 6'd25, prediv)
    `CHK("ctrl_f", 8'h23, ctrl_f)
    `CHK("byp_f", 2'b00, byp_f)
    `CHK("res_f", 5'b10110, res_f)
    `CHK("cp_f", 8'h06, cp_f)
    `CHK("sref_f", 8'h00, sref_f)
    `CHK("od_f", 8'h33, od_f)
    $display("test defaults done");
    for (i = 0; i < 9; i++) host_u.wr_byte(8'h07 + i[7:0], 8'h96 ^ i[7:0]);
    for (i = 0; i < 9; i++) check_rd(8'h07 + i[7:0], 8'h96 ^ i[7:0], 1'b1);
    `CHK("fb_div", 11'h594, fb_div)
    `CHK("spread_fb", 16'h9091, spread_fb)
    `CHK("prediv", 6'h17, prediv)
    `CHK("ctrl_f", 8'h96, ctrl_f)
    `CHK("byp_f", 2'b10, byp_f)
    `CHK("res_f", 5'b10010, res_f)
    `CHK("cp_f", 8'h92, cp_f)
    `CHK("sref_f", 8'h93, sref_f)
    `CHK("od_f", 8'h9e, od_f)
    $display("test readback done");
    host_u.wr_byte(8'h07, 8'h40);
    host_u.wr_byte(8'h0b, 8'hff);
    `CHK("pump_num", 8'h7e, pump_num)
    `CHK("pump_div", 5'd27, pump_div)
    $display("test pump done");
    host_u.wr_byte(8'h10, 8'hff);
    check_rd(8'h10, 8'h00, 1'b0);
    check_rd(8'h06, 8'h00, 1'b0);
    check_rd(8'h0f, 8'h9e, 1'b1);
    clk_en_i = 1'b0;
    host_u.wr_byte(8'h09, 8'h00);
    clk_en_i = 1'b1;
    check_rd(8'h09, 8'h94, 1'b1);
    reset_n_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    check_rd(8'h0a, 8'hb2, 1'b1);
    $display("test refusals done");
    stop_test;
  end
endmodule // pll1_config_register_bank_tb

//--- pump_current_calc.v
/*
  Charge-pump current weighting: numerator and divisor in units of the base current.
  Assumes pure combinational use; the analog path applies the ratio.
*/
`timescale 1ns/1ns
module pump_current_calc (
  input wire bias_select_bit_i,
  input wire [5:0] weights_i,
  input wire pump_divide_24_i,
  input wire pump_divide_3_i,
  output wire [7:0] numerator_o,
  output wire [4:0] divisor_o
);
  // ----------------------------------------------------------------------------
  // Formula
  // ----------------------------------------------------------------------------
  // Weights bit5..0 are x32..x1 so the byte is already the binary sum
  wire [6:0] sum = {1'b0, weights_i};
  // Doubling the bias is a left shift
  assign numerator_o = bias_select_bit_i ? {sum, 1'b0} : {1'b0, sum};
  // Divisor zero when both terms clear; consumer must treat as invalid
  assign divisor_o = (pump_divide_24_i ? 5'h18 : 5'h00) + (pump_divide_3_i ? 5'h03 : 5'h00);
endmodule // pump_current_calc
